// file: rtl/pllcg_top.sv
// Clock generator control: PLL control/status, prescaler, multiplier, group dividers
`include "pllcg_params.svh"
module pllcg_top #(
  parameter int OSC_COUNT  = `PLLCG_OSC_COUNT,   // Oscillator settle count
  parameter int LOCK_COUNT = `PLLCG_LOCK_TIME_NS / `PLLCG_CLK_PERIOD_NS  // Lock delay
) (
  input  wire logic        clock,               // Reference clock, 200 MHz
  input  wire logic        rstn,                // Async reset, active low
  input  wire logic        regWrite,            // Register write strobe
  input  wire logic        regRead,             // Register read strobe
  input  wire logic [15:0] regAddr,             // I/O word address
  input  wire logic [15:0] regWdata,            // Write data
  output logic      [15:0] regRdata_q,          // Read data, registered
  input  wire logic        memifClockSelectPin, // High: external memory clock
  input  wire logic        oscCountDisable,     // Oscillator counter disabled
  input  wire logic        testMode,            // Test mode forces stable
  input  wire logic        clockGenIdle,        // Clock generator idle request
  output logic             subsysTick_q,        // Subsystem group enable
  output logic             fastTick_q,          // Fast group enable
  output logic             slowTick_q,          // Slow group enable
  output logic             memifTick_q,         // Memory group internal enable
  output logic             memifUseExternal_q,  // Memory interface uses external clock
  output logic             pllInReset_q,        // PLL reset asserted
  output logic             pllPoweredDown_q,    // PLL power-down
  output logic             oscPoweredDown_q     // Oscillator power-down
);
  logic        pllEnable_q, pll_power_down_q, osc_power_down_q, pll_reset_bit_q;
  logic [4:0]  mult_q, presc_q;
  logic        prescEn_q, clkMode0_q, clockIdle_q;
  logic [1:0]  div1_q, div2_q, div3_q;
  logic [1:0]  selSync_q;
  logic [15:0] oscCnt_q;
  logic [15:0] lockCnt_q;
  logic [4:0]  prescCnt_q;
  logic        refTick, pllTick, srcTick, fastTick, slowTick, memifTick;
  logic        stable, locked;
  pllcg_pkg::pllcg_lock_type lock_q;

  // Register writes; reserved bits are dropped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pllEnable_q <= 1'b0;
      pll_power_down_q  <= 1'b0;
      osc_power_down_q  <= 1'b0;
      pll_reset_bit_q    <= 1'b1;
      mult_q      <= 5'h00;
      presc_q     <= 5'h00;
      prescEn_q   <= 1'b1;
      div1_q      <= 2'h3;
      div2_q      <= 2'h3;
      div3_q      <= 2'h3;
      clkMode0_q  <= 1'b0;
    end else if (regWrite) begin
      unique case (regAddr)
        `PLLCG_CSR_OFFSET: begin
          pllEnable_q <= regWdata[`PLLCG_BIT_EN];
          pll_power_down_q  <= regWdata[`PLLCG_BIT_PWRDN];
          osc_power_down_q  <= regWdata[`PLLCG_BIT_OSCPD];
          pll_reset_bit_q    <= regWdata[`PLLCG_BIT_RST];
        end
        `PLLCG_MULT_OFFSET:  mult_q <= regWdata[4:0];
        `PLLCG_PRESC_OFFSET: begin
          presc_q   <= regWdata[4:0];
          prescEn_q <= regWdata[`PLLCG_BIT_PRESC_EN];
        end
        `PLLCG_DIV1_OFFSET:  div1_q <= regWdata[1:0];
        `PLLCG_DIV2_OFFSET:  div2_q <= regWdata[1:0];
        `PLLCG_DIV3_OFFSET:  div3_q <= regWdata[1:0];
        `PLLCG_CLKMODE_OFFSET: clkMode0_q <= regWdata[0];
        default: ;
      endcase
    end
  end

  // Register reads; unmapped addresses read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regRdata_q <= 16'h0000;
    end else if (regRead) begin
      regRdata_q <= 16'h0000;
      unique case (regAddr)
        `PLLCG_CSR_OFFSET: begin
          regRdata_q[`PLLCG_BIT_EN]     <= pllEnable_q;
          regRdata_q[`PLLCG_BIT_PWRDN]  <= pll_power_down_q;
          regRdata_q[`PLLCG_BIT_OSCPD]  <= osc_power_down_q;
          regRdata_q[`PLLCG_BIT_RST]    <= pll_reset_bit_q;
          regRdata_q[`PLLCG_BIT_LOCK]   <= locked;
          regRdata_q[`PLLCG_BIT_STABLE] <= stable;
        end
        `PLLCG_MULT_OFFSET:  regRdata_q[4:0] <= mult_q;
        `PLLCG_PRESC_OFFSET: regRdata_q <= {prescEn_q, 10'h000, presc_q};
        `PLLCG_DIV1_OFFSET:  regRdata_q <= {14'h0000, div1_q};
        `PLLCG_DIV2_OFFSET:  regRdata_q <= {14'h0000, div2_q};
        `PLLCG_DIV3_OFFSET:  regRdata_q <= {14'h0000, div3_q};
        `PLLCG_CLKMODE_OFFSET: regRdata_q[0] <= clkMode0_q;
        `PLLCG_IDLE_OFFSET:  regRdata_q[0] <= clockIdle_q;
        default: ;
      endcase
    end
  end

  // Idle request is an outside level, synchronised before use
  logic [1:0] idleSync_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idleSync_q  <= 2'b00;
      clockIdle_q <= 1'b0;
    end else begin
      idleSync_q  <= {idleSync_q[0], clockGenIdle};
      clockIdle_q <= idleSync_q[1];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      oscCnt_q <= 16'h0000;
    end else if (oscCnt_q != 16'(OSC_COUNT)) begin
      oscCnt_q <= oscCnt_q + 16'h0001;
    end
  end
  assign stable = (oscCnt_q == 16'(OSC_COUNT)) || oscCountDisable || testMode;

  // lock model: acquire time after reset release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock_q    <= pllcg_pkg::LOCK_RESET;
      lockCnt_q <= 16'h0000;
    end else if (pll_reset_bit_q) begin
      lock_q    <= pllcg_pkg::LOCK_RESET;
      lockCnt_q <= 16'h0000;
    end else if (pll_power_down_q) begin
      lock_q    <= pllcg_pkg::LOCK_DOWN;
      lockCnt_q <= 16'h0000;
    end else begin
      unique case (lock_q)
        pllcg_pkg::LOCK_RESET, pllcg_pkg::LOCK_DOWN: lock_q <= pllcg_pkg::LOCK_ACQUIRE;
        pllcg_pkg::LOCK_ACQUIRE: begin
          if (lockCnt_q == 16'(LOCK_COUNT - 1)) begin
            lock_q <= pllcg_pkg::LOCK_DONE;
          end else begin
            lockCnt_q <= lockCnt_q + 16'h0001;
          end
        end
        pllcg_pkg::LOCK_DONE: ;
      endcase
    end
  end
  assign locked = (lock_q == pllcg_pkg::LOCK_DONE);

  // prescaler divides reference by value plus one
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prescCnt_q <= 5'h00;
    end else if (!prescEn_q || prescCnt_q >= presc_q) begin
      prescCnt_q <= 5'h00;
    end else begin
      prescCnt_q <= prescCnt_q + 5'h01;
    end
  end
  assign refTick = !prescEn_q || (prescCnt_q >= presc_q);

  // multiplier only gates the model; reserved codes stop the output
  // A tick cannot come faster than the reference, so one per prescaled period stands in
  assign pllTick = refTick && (mult_q >= 5'h02) && (mult_q <= 5'h0f) && locked;

  // bypass selects reference directly; enable selects PLL output
  assign srcTick = pllEnable_q ? pllTick : 1'b1;

  // all groups chain from the subsystem path
  pllcg_divider fastDiv (
    .clock   (clock),
    .rstn    (rstn),
    .tickIn  (srcTick),
    .ratio   (div1_q),
    .tickOut (fastTick)
  );
  pllcg_divider slowDiv (
    .clock   (clock),
    .rstn    (rstn),
    .tickIn  (srcTick),
    .ratio   (div2_q),
    .tickOut (slowTick)
  );
  pllcg_divider memifDiv (
    .clock   (clock),
    .rstn    (rstn),
    .tickIn  (srcTick),
    .ratio   (div3_q),
    .tickOut (memifTick)
  );

  // Select pin is a board level, synchronised first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      selSync_q <= 2'b00;
    end else begin
      selSync_q <= {selSync_q[0], memifClockSelectPin};
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      subsysTick_q       <= 1'b0;
      fastTick_q         <= 1'b0;
      slowTick_q         <= 1'b0;
      memifTick_q        <= 1'b0;
      memifUseExternal_q <= 1'b0;
      pllInReset_q       <= 1'b1;
      pllPoweredDown_q   <= 1'b0;
      oscPoweredDown_q   <= 1'b0;
    end else begin
      subsysTick_q <= srcTick;
      fastTick_q   <= fastTick;
      slowTick_q   <= slowTick;
      // low pin: internal bridge clock; high pin: external clock
      memifTick_q        <= memifTick && !selSync_q[1];
      memifUseExternal_q <= selSync_q[1];
      // PLL held in reset while bit set
      pllInReset_q     <= pll_reset_bit_q;
      pllPoweredDown_q <= pll_power_down_q;
      // oscillator power-down, immediate or at idle
      oscPoweredDown_q <= osc_power_down_q && (clkMode0_q || clockIdle_q);
    end
  end
endmodule

// file: rtl/pllcg_params.svh
// Offsets, field positions, reset values and timing counts of the clock group control block
`ifndef PLLCG_PARAMS_SVH
`define PLLCG_PARAMS_SVH
`define PLLCG_CSR_OFFSET      16'h1c80
`define PLLCG_MULT_OFFSET     16'h1c88
`define PLLCG_PRESC_OFFSET    16'h1c8a
`define PLLCG_DIV1_OFFSET     16'h1c8c
`define PLLCG_DIV2_OFFSET     16'h1c8e
`define PLLCG_DIV3_OFFSET     16'h1c90
`define PLLCG_CLKMODE_OFFSET  16'h1c98
`define PLLCG_IDLE_OFFSET     16'h1c9a
`define PLLCG_BIT_EN          0
`define PLLCG_BIT_PWRDN       1
`define PLLCG_BIT_OSCPD       2
`define PLLCG_BIT_RST         3
`define PLLCG_BIT_LOCK        5
`define PLLCG_BIT_STABLE      6
`define PLLCG_BIT_PRESC_EN    15
`define PLLCG_BIT_DIV_EN      15
`define PLLCG_CSR_RESET       16'h0048
`define PLLCG_PRESC_RESET     16'h8000
`define PLLCG_DIVX_RESET      16'h0003
`define PLLCG_OSC_COUNT       41032
`define PLLCG_LOCK_TIME_NS    10000
`define PLLCG_CLK_PERIOD_NS   5
`endif

// file: rtl/pllcg_pkg.sv
// Types of the clock group control block
package pllcg_pkg;
  typedef enum logic [1:0] {
    LOCK_RESET   = 2'b00,
    LOCK_ACQUIRE = 2'b01,
    LOCK_DONE    = 2'b10,
    LOCK_DOWN    = 2'b11
  } pllcg_lock_type;
endpackage

// file: rtl/pllcg_divider.sv
// Programmable clock-enable divider, divide by 1, 2 or 4
module pllcg_divider (
  input  wire logic       clock,     // System clock
  input  wire logic       rstn,      // Async reset, active low
  input  wire logic       tickIn,    // Source rate enable
  input  wire logic [1:0] ratio,     // 0:/1 1:/2 other:/4
  output logic            tickOut    // Divided enable pulse
);
  logic [1:0] count_q;
  logic [1:0] limit;

  // Terminal count per ratio code
  always_comb begin
    unique case (ratio)
      2'b00:   limit = 2'h0;
      2'b01:   limit = 2'h1;
      default: limit = 2'h3;
    endcase
  end

  // Count source ticks, emit one tick at terminal count
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_q <= 2'h0;
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (tickIn) begin
        if (count_q >= limit) begin
          count_q <= 2'h0;
          tickOut <= 1'b1;
        end else begin
          count_q <= count_q + 2'h1;
        end
      end
    end
  end
endmodule

// file: bench/pllcg_chk.sv
// Port-level assertions for the clock group control block
module pllcg_chk (
  input wire logic        clock,               // Reference clock
  input wire logic        rstn,                // Async reset, active low
  input wire logic        regWrite,            // Write strobe
  input wire logic        regRead,             // Read strobe
  input wire logic [15:0] regAddr,             // Word address
  input wire logic [15:0] regWdata,            // Write data
  input wire logic [15:0] regRdata_q,          // Read data
  input wire logic        memifClockSelectPin, // Memory clock select
  input wire logic        subsysTick_q,        // Subsystem group enable
  input wire logic        fastTick_q,          // Fast group enable
  input wire logic        slowTick_q,          // Slow group enable
  input wire logic        memifTick_q,         // Memory group enable
  input wire logic        memifUseExternal_q,  // External memory clock
  input wire logic        pllInReset_q,        // PLL reset state
  input wire logic        pllPoweredDown_q,    // PLL power-down
  input wire logic        oscPoweredDown_q     // Oscillator power-down
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Control register write seen on the bus
  wire logic csrWr = regWrite && regAddr == 16'h1c80;
  a_ext_gate_off: assert property (memifUseExternal_q |-> !memifTick_q)
    else $error("memory enable ticks while on external clock");
  a_sel_pin_follow: assert property (memifClockSelectPin [*5] |-> memifUseExternal_q)
    else $error("select output ignores the pin");
  a_rst_bit_clear: assert property (csrWr && !regWdata[3] |-> ##[1:2] !pllInReset_q)
    else $error("PLL reset not released");
  a_pll_pwrdn_set: assert property (csrWr && regWdata[1] |-> ##[1:2] pllPoweredDown_q)
    else $error("PLL power-down not applied");
  // state after reset, still shown at the first edge after release
  a_reset_values: assert property ($rose(rstn) |-> pllInReset_q && !pllPoweredDown_q
    && !oscPoweredDown_q)
    else $error("wrong state after reset");
  a_lock_in_reset: assert property (regRead && regAddr == 16'h1c80 && pllInReset_q
    && $past(pllInReset_q) |=> !regRdata_q[5])
    else $error("lock flag set during PLL reset");
  a_csr_reserved: assert property (regRead && regAddr == 16'h1c80 |=>
    regRdata_q[15:7] == 9'h000 && !regRdata_q[4])
    else $error("reserved control bits not zero");
  // slow group at /4, its divider is never reprogrammed
  a_slow_spacing: assert property (slowTick_q |=> !slowTick_q [*3])
    else $error("slow enable too frequent");
  a_fast_from_subsys: assert property (fastTick_q |-> $past(subsysTick_q))
    else $error("fast enable without a subsystem enable");
endmodule

bind pllcg_top pllcg_chk pllcg_chk_i (.clock, .rstn, .regWrite, .regRead, .regAddr,
  .regWdata, .regRdata_q, .memifClockSelectPin, .subsysTick_q, .fastTick_q, .slowTick_q,
  .memifTick_q, .memifUseExternal_q, .pllInReset_q, .pllPoweredDown_q, .oscPoweredDown_q);

// file: bench/pllcg_tb.sv
// Self-checking bench for the clock group control block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OSC = 20;              // Short settle count keeps the run brief
  localparam int LCK = 4;               // Short lock delay
  localparam logic [15:0] CSR = 16'h1c80;
  logic        clock, rstn, regWrite, regRead, memifClockSelectPin, clockGenIdle;
  logic        oscCountDisable, testMode;
  logic        subsysTick_q, fastTick_q, slowTick_q, memifTick_q, memifUseExternal_q;
  logic        pllInReset_q, pllPoweredDown_q, oscPoweredDown_q;
  logic [15:0] regAddr, regWdata, regRdata_q;
  int          miscompares, totalChecks;

  pllcg_top #(.OSC_COUNT(OSC), .LOCK_COUNT(LCK)) pllcg_top_i (.clock, .rstn, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata_q, .memifClockSelectPin,
    .oscCountDisable, .testMode, .clockGenIdle, .subsysTick_q, .fastTick_q,
    .slowTick_q, .memifTick_q, .memifUseExternal_q, .pllInReset_q, .pllPoweredDown_q,
    .oscPoweredDown_q);

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // Read strobe, data lands one cycle later
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdata_q, exp);
  endtask
  // Settle past the pipeline, then count every group enable; an unknown counts as a tick
  task automatic count_ticks(input int n, input int eMem, input int eSub, input int eFast,
                             input int eSlow);
    int nMem = 0;
    int nSub = 0;
    int nFast = 0;
    int nSlow = 0;
    repeat (6) @(posedge clock);
    repeat (n) begin
      @(posedge clock);
      #1;
      if (memifTick_q !== 1'b0) nMem++;
      if (subsysTick_q !== 1'b0) nSub++;
      if (fastTick_q !== 1'b0) nFast++;
      if (slowTick_q !== 1'b0) nSlow++;
    end
    chk(16'(nMem), 16'(eMem));
    chk(16'(nSub), 16'(eSub));
    chk(16'(nFast), 16'(eFast));
    chk(16'(nSlow), 16'(eSlow));
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Watchdog well beyond the expected run
  initial begin
    #20us;
    miscompares++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 16'h0000;
    regWdata = 16'h0000;
    memifClockSelectPin = 1'b0;
    clockGenIdle = 1'b0;
    oscCountDisable = 1'b0;
    testMode = 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rd(CSR, 16'h0008);
    rd(16'h1c84, 16'h0000);
    rd(16'h1c90, 16'h0003);
    // slow group stays at /4, never above the fast group
    count_ticks(40, 10, 40, 10, 10);
    // fast group to /2 first, its peripherals idle
    wr(16'h1c8c, 16'h0001);
    // memory group follows to /2 with no memory traffic
    wr(16'h1c90, 16'h0001);
    count_ticks(40, 20, 40, 20, 10);
    @(posedge clock);
    // external clock rate is kept outside this block
    memifClockSelectPin <= 1'b1;
    count_ticks(40, 0, 40, 20, 10);
    chk(16'(memifUseExternal_q), 16'h0001);
    @(posedge clock);
    memifClockSelectPin <= 1'b0;
    count_ticks(40, 20, 40, 20, 10);
    chk(16'(memifUseExternal_q), 16'h0000);
    repeat (OSC) @(posedge clock);
    rd(CSR, 16'h0048);
    // bypass and PLL held in reset, both in one write
    wr(CSR, 16'h0008);
    // new multiplier and prescaler in reset; reserved bits dropped
    wr(16'h1c88, 16'hffe4);
    rd(16'h1c88, 16'h0004);
    wr(16'h1c8a, 16'hffe1);
    rd(16'h1c8a, 16'h8001);
    // 200 cycles of 5 ns make the wait
    repeat (200) @(posedge clock);
    wr(CSR, 16'h0000);
    rd(CSR, 16'h0040);
    repeat (LCK + 4) @(posedge clock);
    rd(CSR, 16'h0060);
    wr(CSR, 16'h0001);
    rd(CSR, 16'h0061);
    // PLL mode runs at one in two, below the bypass rate
    // fast group to /1 at this halved rate
    wr(16'h1c8c, 16'h0000);
    count_ticks(40, 10, 20, 20, 5);
    // memory group to /1, equal to the fast group
    wr(16'h1c90, 16'h0000);
    count_ticks(40, 20, 20, 20, 5);
    wr(16'h1c88, 16'h0000);
    count_ticks(40, 0, 0, 0, 0);
    // oscillator waits for idle when the mode bit is clear
    wr(CSR, 16'h000e);
    repeat (4) @(posedge clock);
    #1 chk(16'(pllPoweredDown_q), 16'h0001);
    chk(16'(oscPoweredDown_q), 16'h0000);
    @(posedge clock);
    clockGenIdle <= 1'b1;
    repeat (6) @(posedge clock);
    #1 chk(16'(oscPoweredDown_q), 16'h0001);
    @(posedge clock);
    clockGenIdle <= 1'b0;
    wr(CSR, 16'h0008);
    wr(16'h1c98, 16'h0001);
    #1 chk(16'(oscPoweredDown_q), 16'h0000);
    wr(CSR, 16'h000c);
    repeat (3) @(posedge clock);
    #1 chk(16'(oscPoweredDown_q), 16'h0001);
    // Second reset mid-run restarts the settle counter
    @(posedge clock);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rd(CSR, 16'h0008);
    // test mode and a disabled counter force stable
    @(posedge clock);
    testMode <= 1'b1;
    rd(CSR, 16'h0048);
    @(posedge clock);
    testMode <= 1'b0;
    oscCountDisable <= 1'b1;
    rd(CSR, 16'h0048);
    @(posedge clock);
    oscCountDisable <= 1'b0;
    rd(CSR, 16'h0008);
    report_and_stop();
  end
endmodule
